// ==== i2c_master_model.sv ====
// Behavioural bus master on the serial lines
`timescale 1ns/100ps
module i2c_master_model #(
  parameter int H = 60
) (
  // Pacing clock
  input  wire logic clk_i,
  // Resolved lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // 1 = released, 0 = pulled low
  output logic      scl_o,
  output logic      sda_o
);
  int tmo = 0;
  // Lines released from time zero
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Quarter bit pause
  task automatic hw();
    repeat (H) @(posedge clk_i);
  endtask
  // Release clock; a slave may stretch it, so wait bounded
  task automatic rise();
    int n;
    n = 0;
    scl_o <= 1'b1;
    @(posedge clk_i);
    while (scl_i !== 1'b1 && n < 40000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40000)
      tmo++;
  endtask
  // One bit, data changed only while clock low
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    hw();
    rise();
    hw();
    r = sda_i;
    hw();
    scl_o <= 1'b0;
    hw();
  endtask
  task automatic start();
    sda_o <= 1'b1;
    rise();
    hw();
    sda_o <= 1'b0;
    hw();
    scl_o <= 1'b0;
    hw();
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    hw();
    rise();
    hw();
    sda_o <= 1'b1;
    hw();
  endtask
  // Byte out MSB first, ninth bit returns the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nak, r);
  endtask
endmodule

// ==== sync_two_ff.sv ====
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module sync_two_ff #(
  parameter int             W  = 1,
  parameter logic [W-1:0]   RV = '0
) (
  // Destination clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Level crossing
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // First stage feeds the second only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= RV;
      q_o    <= RV;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

// ==== two_wire_data_path_control.sv ====
// Two-wire serial unit: data path, transfer control and register file
// How it works
// [R1] Slave direction flag is read-only: high while slave transmits, low while receiving.
// [R2] Repeat-start request makes the master issue a start, then the address byte.
// [R3] A received not-acknowledge ends mastership and clears the repeat-start request.
// [R4] Address byte is own address bits 7..1 with master direction as bit 0.
// [R5] Master direction clear means master transmits; set means master receives.
// [R6] Transmit buffer resets to ones; loads shift register on matching slave-read address.
// [R7] In transmit, buffer loads shift register after a byte acknowledged with zero.
// [R8] Receive buffer holds last data byte, or the calling address after a slave address match.
// [R9] New byte enters receive buffer only after previous read; clock held low meanwhile.
// [R10] Reading the receive buffer clears the receive flag.
// [R11] After the flag clears, next byte loads and sets the receive flag again.
// [R12] Summary flag is the OR of receive, transmit, transmit-fail and no-ack flags.
// [R13] Address-hit flag is read-only, slave only, set when first byte matches.
// [R14] Receive flag sets when the receive buffer loads a new byte.
// [R15] Transmit flag sets when buffer or address loads the shift register.
// [R16] Master only: no-ack flag sets when a byte or address gets no acknowledge.
`timescale 1ns/100ps
module two_wire_data_path_control (
  // System clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Serial bus, open drain
  input  wire logic        link_clk_i,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o
);

  // Core domain state
  logic                   ack_q;
  logic [31:0]            dat_q;
  logic                   rx_flag_q;
  logic                   tx_flag_q;
  logic                   fail_flag_q;
  logic                   nak_flag_q;
  logic                   master_en_q;
  logic                   ack_resp_q;
  logic                   restart_q;
  logic                   master_dir_q;
  logic [7:0]             own_addr_q;
  logic [7:0]             txbuf_q;
  logic [7:0]             rxbuf_q;
  logic [7:0]             tx_hold_q;
  logic                   rx_ack_q;
  logic                   tx_ack_q;
  logic [3:0]             evt_seen_q;
  logic [7:0]             idx;
  logic [7:0]             rdata;
  logic                   req;
  logic                   wr;
  logic                   rd;
  logic                   rd_rx;
  logic                   rx_load;
  logic                   tx_load;
  logic [3:0]             evt_p;
  two_wire_pkg::to_core_s core_s;
  two_wire_pkg::to_core_s core_l;
  two_wire_pkg::to_link_s link_c;
  two_wire_pkg::to_link_s link_s;

  // Link domain state
  two_wire_pkg::link_state_e st_q;
  logic       lrst;
  logic [1:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       busy_q;
  logic [7:0] div_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       scl_oe_n_q;
  logic       sda_oe_n_q;
  logic       pin_lvl_q;
  logic       mas_q;
  logic       tx_q;
  logic       first_q;
  logic       hold_rx_q;
  logic       hit_q;
  logic       sdir_q;
  logic       ackb_q;
  logic [7:0] rx_word_q;
  logic       rx_req_q;
  logic       tx_req_q;
  logic [3:0] evt_q;
  logic       rise;
  logic       fall;
  logic       start_d;
  logic       stop_d;
  logic       tick;

  // Wishbone decode; unmapped offsets read zero and ignore writes
  assign idx   = adr_i[9:2];
  assign req   = cyc_i & stb_i & ~ack_q;
  assign wr    = req & we_i & sel_i[0];
  assign rd    = req & ~we_i;
  assign rd_rx = rd & (idx == two_wire_pkg::IDX_RXBUF);
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // Pending handshakes from the link
  assign rx_load = (core_s.rx_req != rx_ack_q) & ~rx_flag_q; // R9
  assign tx_load = core_s.tx_req != tx_ack_q;
  assign evt_p   = core_s.evt ^ evt_seen_q;

  // One registered answer per request, one cycle after it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // Read data selection
  always_comb
  begin
    rdata = 8'h00;
    case (idx)
      two_wire_pkg::IDX_STATUS:
      begin
        rdata[two_wire_pkg::ST_RXF]  = rx_flag_q;
        rdata[two_wire_pkg::ST_TXF]  = tx_flag_q;
        rdata[two_wire_pkg::ST_FAIL] = fail_flag_q;
        rdata[two_wire_pkg::ST_NAK]  = nak_flag_q;
        rdata[two_wire_pkg::ST_ACKB] = core_s.ack_bit;
        rdata[two_wire_pkg::ST_MEN]  = master_en_q;
        rdata[two_wire_pkg::ST_ACKR] = ack_resp_q;
      end
      two_wire_pkg::IDX_CTRL:
      begin
        rdata[two_wire_pkg::CT_HIT]  = core_s.addr_hit; // R13
        rdata[two_wire_pkg::CT_SDIR] = core_s.slave_dir; // R1
        rdata[two_wire_pkg::CT_RST]  = restart_q;
        rdata[two_wire_pkg::CT_DIR]  = master_dir_q;
      end
      two_wire_pkg::IDX_OWNADDR: rdata = own_addr_q;
      two_wire_pkg::IDX_TXBUF:   rdata = txbuf_q;
      two_wire_pkg::IDX_RXBUF:   rdata = rxbuf_q; // R8
      two_wire_pkg::IDX_SUMMARY:
        rdata[two_wire_pkg::SUM_BIT] = rx_flag_q | tx_flag_q | fail_flag_q | nak_flag_q; // R12
      default:   rdata = 8'h00;
    endcase
  end

  // Read data register, held until the next read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h0000_0000;
    else if (rd)
      dat_q <= {24'h00_0000, rdata};
  end

  // Event flags; a hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_flag_q   <= 1'b0;
      tx_flag_q   <= 1'b0;
      fail_flag_q <= 1'b0;
      nak_flag_q  <= 1'b0;
    end
    else
    begin
      if (rx_load)
        rx_flag_q <= 1'b1; // R11 R14
      else if (rd_rx)
        rx_flag_q <= 1'b0; // R10
      if (tx_load | evt_p[two_wire_pkg::EV_ADDR])
        tx_flag_q <= 1'b1; // R15
      else if (wr && idx == two_wire_pkg::IDX_STATUS && dat_i[two_wire_pkg::ST_TXF])
        tx_flag_q <= 1'b0;
      if (evt_p[two_wire_pkg::EV_FAIL])
        fail_flag_q <= 1'b1;
      else if (wr && idx == two_wire_pkg::IDX_STATUS && dat_i[two_wire_pkg::ST_FAIL])
        fail_flag_q <= 1'b0;
      if (evt_p[two_wire_pkg::EV_NAK])
        nak_flag_q <= 1'b1; // R16
      else if (wr && idx == two_wire_pkg::IDX_STATUS && dat_i[two_wire_pkg::ST_NAK])
        nak_flag_q <= 1'b0;
    end
  end

  // Software control; a write to the repeat request beats the hardware clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      master_en_q  <= 1'b0;
      ack_resp_q   <= 1'b0;
      restart_q    <= 1'b0;
      master_dir_q <= 1'b0;
      own_addr_q   <= two_wire_pkg::RST_OWNADDR;
      txbuf_q      <= two_wire_pkg::RST_TXBUF; // R6
    end
    else
    begin
      if (wr && idx == two_wire_pkg::IDX_STATUS)
      begin
        master_en_q <= dat_i[two_wire_pkg::ST_MEN];
        ack_resp_q  <= dat_i[two_wire_pkg::ST_ACKR];
      end
      if (wr && idx == two_wire_pkg::IDX_CTRL)
      begin
        restart_q    <= dat_i[two_wire_pkg::CT_RST];
        master_dir_q <= dat_i[two_wire_pkg::CT_DIR];
      end
      else if (evt_p[two_wire_pkg::EV_RCLR])
        restart_q <= 1'b0; // R3
      if (wr && idx == two_wire_pkg::IDX_OWNADDR)
        own_addr_q <= dat_i[7:0];
      if (wr && idx == two_wire_pkg::IDX_TXBUF)
        txbuf_q <= dat_i[7:0];
    end
  end

  // Word handshakes; link words stay still until the ack toggle returns
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rxbuf_q    <= two_wire_pkg::RST_RXBUF;
      tx_hold_q  <= two_wire_pkg::RST_TXBUF;
      rx_ack_q   <= 1'b0;
      tx_ack_q   <= 1'b0;
      evt_seen_q <= 4'h0;
    end
    else
    begin
      evt_seen_q <= core_s.evt;
      if (rx_load)
      begin
        rxbuf_q  <= rx_word_q; // R9
        rx_ack_q <= ~rx_ack_q;
      end
      if (tx_load)
      begin
        tx_hold_q <= txbuf_q; // R6 R7
        tx_ack_q  <= ~tx_ack_q;
      end
    end
  end

  // Control levels toward the link
  assign link_c = '{rx_ack: rx_ack_q, tx_ack: tx_ack_q, master_en: master_en_q,
                    master_dir: master_dir_q, restart: restart_q, ack_resp: ack_resp_q,
                    own_addr: own_addr_q[7:1]};
  assign core_l = '{rx_req: rx_req_q, tx_req: tx_req_q, evt: evt_q, slave_dir: sdir_q,
                    addr_hit: hit_q, ack_bit: ackb_q};

  // Crossings between the two domains
  sync_two_ff #(.W(1), .RV(1'b1)) u_rst_sync (
    .clk_i (link_clk_i), .rst_i (1'b0), .d_i (rst_i), .q_o (lrst));
  sync_two_ff #(.W(2), .RV(2'b11)) u_pin_sync (
    .clk_i (link_clk_i), .rst_i (lrst), .d_i ({scl_i, sda_i}), .q_o (pin_s));
  sync_two_ff #(.W($bits(two_wire_pkg::to_link_s))) u_ctl_sync (
    .clk_i (link_clk_i), .rst_i (lrst), .d_i (link_c), .q_o (link_s));
  sync_two_ff #(.W($bits(two_wire_pkg::to_core_s))) u_sts_sync (
    .clk_i (clk_i), .rst_i (rst_i), .d_i (core_l), .q_o (core_s));

  // Bus conditions seen on the synchronised lines
  assign scl_s   = pin_s[1];
  assign sda_s   = pin_s[0];
  assign rise    = scl_s & ~scl_p_q;
  assign fall    = ~scl_s & scl_p_q;
  assign start_d = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_d  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign tick    = div_q == two_wire_pkg::SCL_HALF_CYC - 8'h01;

  // Pin drivers come straight from flops
  assign scl_o      = pin_lvl_q;
  assign sda_o      = pin_lvl_q;
  assign scl_oe_n_o = scl_oe_n_q;
  assign sda_oe_n_o = sda_oe_n_q;

  // Line history and busy tracking
  always_ff @(posedge link_clk_i)
  begin
    if (lrst)
    begin
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      busy_q    <= 1'b0;
      pin_lvl_q <= 1'b0;
      div_q     <= 8'h00;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      div_q   <= tick ? 8'h00 : div_q + 8'h01;
      if (start_d)
        busy_q <= 1'b1;
      else if (stop_d)
        busy_q <= 1'b0;
    end
  end

  // Byte engine for master and slave; data moves on falls, samples on rises
  always_ff @(posedge link_clk_i)
  begin
    if (lrst)
    begin
      st_q <= two_wire_pkg::L_IDLE;
      {cnt_q, sh_q, rx_word_q, evt_q} <= 24'h00_0000;
      {scl_oe_n_q, sda_oe_n_q} <= 2'b11;
      {mas_q, tx_q, first_q, hold_rx_q, hit_q, sdir_q, ackb_q, rx_req_q, tx_req_q} <= 9'h000;
    end
    else if (!mas_q && start_d)
    begin
      // A start seen while not master opens a new address phase for the slave
      st_q <= two_wire_pkg::L_BITS;
      {cnt_q, first_q, tx_q, hit_q, sdir_q} <= {4'h0, 4'b1000};
      {scl_oe_n_q, sda_oe_n_q} <= 2'b11;
    end
    else if (!mas_q && stop_d)
    begin
      st_q <= two_wire_pkg::L_IDLE;
      {scl_oe_n_q, sda_oe_n_q, hit_q} <= 3'b110;
    end
    else
    begin
      unique case (st_q)
        two_wire_pkg::L_IDLE:
          if (link_s.master_en && !busy_q)
          begin
            st_q  <= two_wire_pkg::L_START;
            mas_q <= 1'b1;
            hit_q <= 1'b0;
          end
        two_wire_pkg::L_START:
          if (tick)
          begin
            if (!scl_oe_n_q)
              scl_oe_n_q <= 1'b1;
            else if (scl_s && sda_oe_n_q)
              sda_oe_n_q <= 1'b0; // R2
            else if (!sda_oe_n_q)
            begin
              sh_q <= {link_s.own_addr, link_s.master_dir}; // R4
              {cnt_q, first_q, tx_q} <= {4'h0, 2'b11};
              evt_q[two_wire_pkg::EV_ADDR] <= ~evt_q[two_wire_pkg::EV_ADDR];
              if (link_s.restart)
                evt_q[two_wire_pkg::EV_RCLR] <= ~evt_q[two_wire_pkg::EV_RCLR];
              st_q <= two_wire_pkg::L_BITS;
            end
          end
        two_wire_pkg::L_BITS:
        begin
          if (mas_q && tick)
            scl_oe_n_q <= scl_oe_n_q ? ~scl_s : 1'b1;
          if (rise && cnt_q != 4'h8)
          begin
            sh_q  <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
            if (mas_q && tx_q && sda_oe_n_q && !sda_s)
            begin
              // Lost the line to another master
              evt_q[two_wire_pkg::EV_FAIL] <= ~evt_q[two_wire_pkg::EV_FAIL];
              {mas_q, scl_oe_n_q, sda_oe_n_q} <= 3'b011;
              st_q <= two_wire_pkg::L_IDLE;
            end
          end
          else if (fall && cnt_q != 4'h8)
            sda_oe_n_q <= ~(tx_q & ~sh_q[7]);
          else if (fall && tx_q)
          begin
            sda_oe_n_q <= 1'b1;
            st_q       <= two_wire_pkg::L_ACK;
          end
          else if (fall && first_q && !mas_q && sh_q[7:1] != link_s.own_addr)
          begin
            sda_oe_n_q <= 1'b1;
            st_q       <= two_wire_pkg::L_IDLE;
          end
          else if (fall)
          begin
            if (first_q && !mas_q)
            begin
              hit_q  <= 1'b1; // R13
              sdir_q <= sh_q[0]; // R1
            end
            rx_word_q  <= sh_q; // R8
            rx_req_q   <= ~rx_req_q;
            scl_oe_n_q <= 1'b0; // R9
            hold_rx_q  <= 1'b1;
            st_q       <= two_wire_pkg::L_HOLD;
          end
        end
        two_wire_pkg::L_HOLD:
          if (hold_rx_q ? link_s.rx_ack == rx_req_q : link_s.tx_ack == tx_req_q)
          begin
            scl_oe_n_q <= ~mas_q;
            if (hold_rx_q)
            begin
              sda_oe_n_q <= (first_q && !mas_q) ? 1'b0 : link_s.ack_resp;
              st_q       <= two_wire_pkg::L_ACK;
            end
            else
            begin
              sh_q       <= tx_hold_q;
              sda_oe_n_q <= tx_hold_q[7];
              cnt_q      <= 4'h0;
              st_q       <= two_wire_pkg::L_BITS;
            end
          end
        two_wire_pkg::L_ACK:
        begin
          if (mas_q && tick)
            scl_oe_n_q <= scl_oe_n_q ? ~scl_s : 1'b1;
          if (rise && tx_q)
            ackb_q <= sda_s;
          else if (fall)
          begin
            sda_oe_n_q <= 1'b1;
            first_q    <= 1'b0;
            cnt_q      <= 4'h0;
            st_q       <= two_wire_pkg::L_BITS;
            if (mas_q && tx_q && ackb_q)
            begin
              evt_q[two_wire_pkg::EV_NAK] <= ~evt_q[two_wire_pkg::EV_NAK]; // R16
              if (link_s.restart)
                evt_q[two_wire_pkg::EV_RCLR] <= ~evt_q[two_wire_pkg::EV_RCLR]; // R3
              sda_oe_n_q <= 1'b0;
              st_q       <= two_wire_pkg::L_STOP; // R3
            end
            else if (mas_q && ((!tx_q && link_s.ack_resp) || !link_s.master_en))
            begin
              sda_oe_n_q <= 1'b0;
              st_q       <= two_wire_pkg::L_STOP;
            end
            else if (mas_q && link_s.restart)
              st_q <= two_wire_pkg::L_START; // R2
            else if (!mas_q && tx_q && ackb_q)
              st_q <= two_wire_pkg::L_IDLE;
            else if (first_q ? (mas_q ? !link_s.master_dir : sdir_q) : tx_q)
            begin
              // R5 R6 R7
              tx_q       <= 1'b1;
              tx_req_q   <= ~tx_req_q;
              scl_oe_n_q <= 1'b0;
              hold_rx_q  <= 1'b0;
              st_q       <= two_wire_pkg::L_HOLD;
            end
            else
              tx_q <= 1'b0; // R5
          end
        end
        two_wire_pkg::L_STOP:
          if (tick)
          begin
            if (!scl_oe_n_q)
              scl_oe_n_q <= 1'b1;
            else if (scl_s)
            begin
              {sda_oe_n_q, mas_q} <= 2'b10;
              st_q <= two_wire_pkg::L_IDLE;
            end
          end
        default: st_q <= two_wire_pkg::L_IDLE;
      endcase
    end
  end

  // Checks on the core side
  rx_read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (rd_rx && rx_flag_q) |=> !rx_flag_q) else $error("receive flag not cleared by read");
  rx_load_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    $changed(rxbuf_q) |-> !$past(rx_flag_q) && rx_flag_q) else $error("receive buffer overwritten");
  summary_or_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    (rd && idx == two_wire_pkg::IDX_SUMMARY) |=>
      dat_q[1] == ($past(rx_flag_q) | $past(tx_flag_q) | $past(fail_flag_q) | $past(nak_flag_q)))
    else $error("summary mismatch");
  tx_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    $changed(tx_ack_q) |-> tx_flag_q && tx_hold_q == $past(txbuf_q)) else $error("transmit copy wrong");
  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_q) |=> ack_q ##1 !ack_q) else $error("bus answer timing");

  // Checks on the link side
  stall_low_a: assert property (@(posedge link_clk_i) disable iff (lrst) // R9
    (st_q == two_wire_pkg::L_HOLD && hold_rx_q && link_s.rx_ack != rx_req_q) |-> !scl_oe_n_q)
    else $error("clock not held during stall");
  addr_byte_a: assert property (@(posedge link_clk_i) disable iff (lrst) // R4
    (st_q == two_wire_pkg::L_START && tick && scl_oe_n_q && !sda_oe_n_q) |=>
      sh_q == {$past(link_s.own_addr), $past(link_s.master_dir)}) else $error("address byte wrong");
  nak_stop_a: assert property (@(posedge link_clk_i) disable iff (lrst) // R3
    (st_q == two_wire_pkg::L_ACK && fall && mas_q && tx_q && ackb_q) |=>
      st_q == two_wire_pkg::L_STOP && $changed(evt_q[two_wire_pkg::EV_NAK])) else $error("no stop on nak");

endmodule

// ==== two_wire_data_path_control_tb.sv ====
// Self-checking bench for the two-wire data path block
`timescale 1ns/100ps
module two_wire_data_path_control_tb;
  logic        clk_i = 0, link_clk = 0, rst_i = 1;
  logic        cyc = 0, stb = 0, we = 0;
  logic [9:0]  adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat = '0, dat_o;
  logic        ack_o, scl_oe_n, sda_oe_n, p_scl, p_sda, a, a2;
  logic [7:0]  r, d1, d2, d3, d4, oa;
  logic [9:0]  mon = '0;
  logic        scl_d = 1'b1;
  logic [7:0]  q[$];
  int          err_count = 0, n_tests = 0;
  // Open-drain lines with pull-ups
  wire scl_w = scl_oe_n & p_scl;
  wire sda_w = sda_oe_n & p_sda;
  always #5 clk_i = ~clk_i;
  always #6 link_clk = ~link_clk;
  two_wire_data_path_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .link_clk_i(link_clk),
    .scl_i(scl_w), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(), .sda_oe_n_o(sda_oe_n));
  i2c_master_model P (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_o(p_scl), .sda_o(p_sda));
  // Bits seen at each serial clock rise; a stop adds a trailing zero
  always @(posedge clk_i)
  begin
    scl_d <= scl_w;
    if (scl_w && !scl_d)
      mon <= {mon[8:0], sda_w};
  end
  // A stuck partner ends the run through the report at once
  always @(posedge clk_i)
    if (P.tmo != 0)
      report_and_stop();
  task automatic report_and_stop();
    if (P.tmo != 0)
      err_count++;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic cycle held until ack, released after
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    dat <= {24'h0000_00, wd};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] v;
    wb(1'b0, idx, 8'h00, v);
    check(v, e);
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(27785));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(two_wire_pkg::IDX_SUMMARY, 8'h00);
    rchk(two_wire_pkg::IDX_TXBUF, 8'hff);
    rchk(two_wire_pkg::IDX_RXBUF, 8'h00);
    rchk(8'h10, 8'h00);
    repeat (10) @(posedge clk_i);
    // Slave receive: address then two bytes, second one stalled
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    q.push_back({two_wire_pkg::RST_OWNADDR[7:1], 1'b0});
    q.push_back(d1);
    q.push_back(d2);
    P.start();
    P.wbyte(q[0], a);
    check(a, 1'b0);
    rchk(two_wire_pkg::IDX_CTRL, 8'h80);
    rchk(two_wire_pkg::IDX_SUMMARY, 8'h02);
    rchk(two_wire_pkg::IDX_RXBUF, q.pop_front());
    wb(1'b0, two_wire_pkg::IDX_STATUS, 8'h00, r);
    check(r[two_wire_pkg::ST_RXF], 1'b0);
    P.wbyte(d1, a);
    fork
      P.wbyte(d2, a2);
      begin
        repeat (2100) @(posedge clk_i);
        check(scl_w, 1'b0);
        rchk(two_wire_pkg::IDX_RXBUF, q.pop_front());
      end
    join
    check(a2, 1'b0);
    wb(1'b0, two_wire_pkg::IDX_STATUS, 8'h00, r);
    check(r[two_wire_pkg::ST_RXF], 1'b1);
    rchk(two_wire_pkg::IDX_RXBUF, q.pop_front());
    P.stop();
    // Slave transmit from the buffer
    d3 = 8'($urandom);
    wb(1'b1, two_wire_pkg::IDX_TXBUF, d3, r);
    rchk(two_wire_pkg::IDX_TXBUF, d3);
    P.start();
    P.wbyte({two_wire_pkg::RST_OWNADDR[7:1], 1'b1}, a);
    rchk(two_wire_pkg::IDX_CTRL, 8'hc0);
    d4 = 8'($urandom);
    wb(1'b1, two_wire_pkg::IDX_TXBUF, d4, r);
    P.rbyte(1'b0, r);
    check(r, d3);
    P.rbyte(1'b1, r);
    check(r, d4);
    wb(1'b0, two_wire_pkg::IDX_STATUS, 8'h00, r);
    check(r[two_wire_pkg::ST_TXF], 1'b1);
    P.stop();
    rchk(two_wire_pkg::IDX_RXBUF, {two_wire_pkg::RST_OWNADDR[7:1], 1'b1});
    // Master transmit to an absent slave: address out, no-ack, stop
    oa = 8'($urandom);
    wb(1'b1, two_wire_pkg::IDX_STATUS, 8'h40, r);
    wb(1'b1, two_wire_pkg::IDX_OWNADDR, oa, r);
    wb(1'b1, two_wire_pkg::IDX_CTRL, 8'h08, r);
    wb(1'b1, two_wire_pkg::IDX_STATUS, 8'h02, r);
    // Enable dropped early so no second attempt follows the stop
    repeat (20) @(posedge clk_i);
    wb(1'b1, two_wire_pkg::IDX_STATUS, 8'h00, r);
    repeat (4000) @(posedge clk_i);
    check(mon[9:2], {oa[7:1], 1'b0});
    check(mon[1:0], 2'b10);
    rchk(two_wire_pkg::IDX_STATUS, 8'h54);
    wb(1'b0, two_wire_pkg::IDX_CTRL, 8'h00, r);
    check(r[two_wire_pkg::CT_RST], 1'b0);
    rchk(two_wire_pkg::IDX_SUMMARY, 8'h02);
    report_and_stop();
  end
endmodule

// ==== two_wire_pkg.sv ====
// Shared constants and carriers of the two-wire data path block
package two_wire_pkg;

  // Register indices; the Wishbone byte address is four times the index
  localparam logic [7:0] IDX_SUMMARY = 8'haa;
  localparam logic [7:0] IDX_STATUS  = 8'hc0;
  localparam logic [7:0] IDX_OWNADDR = 8'hc1;
  localparam logic [7:0] IDX_CTRL    = 8'hc3;
  localparam logic [7:0] IDX_TXBUF   = 8'hc4;
  localparam logic [7:0] IDX_RXBUF   = 8'hc5;

  // Values after reset
  localparam logic [7:0] RST_OWNADDR = 8'ha0;
  localparam logic [7:0] RST_TXBUF   = 8'hff;
  localparam logic [7:0] RST_RXBUF   = 8'h00;

  // Status register fields
  localparam int ST_RXF  = 7;
  localparam int ST_TXF  = 6;
  localparam int ST_FAIL = 5;
  localparam int ST_NAK  = 4;
  localparam int ST_ACKB = 2;
  localparam int ST_MEN  = 1;
  localparam int ST_ACKR = 0;

  // Control register fields
  localparam int CT_HIT  = 7;
  localparam int CT_SDIR = 6;
  localparam int CT_RST  = 3;
  localparam int CT_DIR  = 0;

  // Summary register field
  localparam int SUM_BIT = 1;

  // Event toggles from link to core
  localparam int EV_ADDR = 0;
  localparam int EV_NAK  = 1;
  localparam int EV_FAIL = 2;
  localparam int EV_RCLR = 3;

  // Half period of the generated serial clock, counted on the link clock
  localparam int SCL_HALF_NS  = 1250;
  localparam int LINK_CLK_KHZ = 83333;
  localparam logic [7:0] SCL_HALF_CYC = 8'(SCL_HALF_NS * LINK_CLK_KHZ / 1_000_000);

  // Link engine states, Gray in the listed order; L_BITS and L_HOLD differ in two bits
  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_START = 3'b001,
    L_BITS  = 3'b011,
    L_ACK   = 3'b010,
    L_HOLD  = 3'b110,
    L_STOP  = 3'b100
  } link_state_e;

  // Core to link
  typedef struct packed {
    logic       rx_ack;
    logic       tx_ack;
    logic       master_en;
    logic       master_dir;
    logic       restart;
    logic       ack_resp;
    logic [6:0] own_addr;
  } to_link_s;

  // Link to core
  typedef struct packed {
    logic       rx_req;
    logic       tx_req;
    logic [3:0] evt;
    logic       slave_dir;
    logic       addr_hit;
    logic       ack_bit;
  } to_core_s;

endpackage
